// ==== rtl/cfg_word_ctrl.sv ====
// Configuration-word feature control: action bits, permanent bits,
// select matching, parallel-encoding handle, TID indicator and
// pre-serialized EPC. Assumes a command decoder delivering one-cycle
// strobes on mclk; the power detector is on-chip logic on mclk.
// How it works
// - Configuration word lives at EPC address 200h
// - Triggered action stays active until chip reset
// - Parallel encoding action is word bit 2
// - Power check action is word bit 4
// - Status flag is bit 15, freely togglable
// - Writing one toggles permanent bit, zero ignored
// - Permanent bit reads one when feature active
// - Single WRITE only, by lock state, never permalocked
// - Action needs exact pointer, length one, mask one
// - At most one action per select
// - Truncated select is ignored entirely
// - Action select leaves protocol state untouched
// - Action triggers work under any lock state
// - Two backscatter levels, maximum is default
// - Default EPC copies TID, extended header zero
// - Parallel encoding: query opens with fixed handle
// - Open tags execute writes as if addressed
// - Power check decides select match
// - Status flag select filters next inventory
// - TID indicator bit shows config word present
module cfg_word_ctrl #(
    parameter logic [47:0] SERIAL_DEFAULT = 48'h0000_0000_0000,
    parameter logic [11:0] MODEL_NUMBER   = 12'h000  // Arbitrary value
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Memory access from the command decoder
    input  wire logic        wr_stb,
    input  wire logic        blk_wr,
    input  wire logic [15:0] wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic        rd_stb,
    input  wire logic [15:0] rd_addr,
    input  wire logic        secured,
    input  wire logic [1:0]  epc_lock,
    // Select command fields
    input  wire logic        sel_stb,
    input  wire logic        sel_truncate,
    input  wire logic [15:0] sel_pointer,
    input  wire logic [7:0]  sel_length,
    input  wire logic        sel_mask,
    // Query and power detector
    input  wire logic        query_stb,
    input  wire logic        power_ok,
    // Results
    output logic [15:0]      rd_data,
    output logic             rd_valid,
    output logic             wr_done,
    output logic             sel_action,
    output logic             sel_match,
    output logic             force_open,
    output logic [15:0]      open_handle,
    output logic             write_broadcast,
    output logic             bs_max,
    output logic             status_flag,
    output logic             flag_filter,
    output logic [95:0]      tid_word,
    output logic [95:0]      epc_default
);

    ////////////////////////////////////////////////////////////////////
    logic [15:0] perm_ff;
    logic        par_enc_ff;
    logic        pwr_chk_ff;
    logic [15:0] nxt_perm;
    logic [15:0] rd_data_ff;
    logic        rd_valid_ff;
    logic        wr_done_ff;
    logic        sel_action_ff;
    logic        sel_match_ff;
    logic        force_open_ff;
    logic        flag_filter_ff;
    logic        filter_arm_ff;
    logic [15:0] open_handle_ff;
    logic [95:0] tid_ff;
    logic [95:0] epc_ff;

    function automatic logic action_hit(input logic [15:0] ptr,
                                        input logic [15:0] addr,
                                        input logic [7:0]  len,
                                        input logic        msk);
        action_hit = (ptr == addr) && (len == cfg_word_pkg::SEL_LEN_ONE) && msk;
    endfunction : action_hit

    ////////////////////////////////////////////////////////////////////
    wire sel_live   = sel_stb && !sel_truncate;
    wire hit_par    = sel_live && action_hit(sel_pointer, cfg_word_pkg::PAR_ENC_ADDR,
                                             sel_length, sel_mask);
    // Parallel encoding wins priority if both hit; pointers are exclusive anyway
    wire hit_pwr    = sel_live && !hit_par && action_hit(sel_pointer,
                      cfg_word_pkg::PWR_CHECK_ADDR, sel_length, sel_mask);
    wire hit_flag   = sel_live && action_hit(sel_pointer, cfg_word_pkg::STATUS_FLAG_ADDR,
                                             sel_length, sel_mask);
    // Lock check: permalock forbids, locked needs secured state
    wire wr_allowed = (epc_lock == cfg_word_pkg::LOCK_OPEN) ||
                      ((epc_lock == cfg_word_pkg::LOCK_LOCKED) && secured);
    wire cfg_wr     = wr_stb && !blk_wr && (wr_addr == cfg_word_pkg::CFG_WORD_ADDR);
    wire perm_wr    = cfg_wr && wr_allowed;
    wire [15:0] word_view = perm_ff
                          | (16'(par_enc_ff) << cfg_word_pkg::PAR_ENC_BIT)
                          | (16'(pwr_chk_ff) << cfg_word_pkg::PWR_CHECK_BIT);

    // TID: class, designer/indicator/model, extended header, serial
    wire [95:0] tid_const = {cfg_word_pkg::TID_CLASS_ID[7:0], 8'h00, 4'h1, MODEL_NUMBER,
                             16'h0000, SERIAL_DEFAULT}
                          | (96'h1 << (95 - cfg_word_pkg::TID_CFG_IND_BIT));
    // Pre-serialized EPC keeps the TID but zeroes the extended header
    wire [95:0] epc_const = {tid_const[95:64], cfg_word_pkg::TID_EXTENDED_TID_HEADER_ZERO,
                             tid_const[47:0]};

    always_comb begin
        nxt_perm = perm_ff;
        if (perm_wr) begin
            nxt_perm = perm_ff ^ (wr_data & cfg_word_pkg::PERM_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (reset) begin
            perm_ff    <= cfg_word_pkg::PERM_RESET;
            par_enc_ff <= 1'b0;
            pwr_chk_ff <= 1'b0;
        end else begin
            perm_ff <= nxt_perm & cfg_word_pkg::PERM_MASK;
            if (hit_par) begin
                par_enc_ff <= 1'b1;
            end
            if (hit_pwr) begin
                pwr_chk_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rd_data_ff    <= 16'h0000;
            rd_valid_ff   <= 1'b0;
            wr_done_ff    <= 1'b0;
            sel_action_ff <= 1'b0;
            sel_match_ff  <= 1'b0;
        end else begin
            rd_valid_ff   <= rd_stb && (rd_addr == cfg_word_pkg::CFG_WORD_ADDR);
            rd_data_ff    <= (rd_stb && rd_addr == cfg_word_pkg::CFG_WORD_ADDR) ?
                             word_view : 16'h0000;
            wr_done_ff    <= perm_wr;
            sel_action_ff <= hit_par || hit_pwr;
            sel_match_ff  <= hit_pwr ? power_ok : (hit_flag ? perm_ff[15] : 1'b0);
        end
    end

    // Forced open lasts from the first query after trigger until reset
    always_ff @(posedge mclk) begin
        if (reset) begin
            force_open_ff  <= 1'b0;
            flag_filter_ff <= 1'b0;
            filter_arm_ff  <= 1'b0;
            open_handle_ff <= 16'h0000;
        end else begin
            if (query_stb && par_enc_ff) begin
                force_open_ff  <= 1'b1;
                open_handle_ff <= cfg_word_pkg::PAR_ENC_HANDLE;
            end
            if (hit_flag) begin
                filter_arm_ff <= 1'b1;
            end else if (query_stb) begin
                filter_arm_ff <= 1'b0;
            end
            if (query_stb) begin
                flag_filter_ff <= filter_arm_ff || hit_flag;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign rd_data         = rd_data_ff;
    assign rd_valid        = rd_valid_ff;
    assign wr_done         = wr_done_ff;
    assign sel_action      = sel_action_ff;
    assign sel_match       = sel_match_ff;
    assign force_open      = force_open_ff;
    // Identity words are fixed; registered only so every output leaves a flop
    always_ff @(posedge mclk) begin
        tid_ff <= tid_const;
        epc_ff <= epc_const;
    end

    ////////////////////////////////////////////////////////////////////
    assign open_handle     = open_handle_ff;
    assign write_broadcast = force_open_ff;
    assign bs_max          = perm_ff[cfg_word_pkg::BS_STRENGTH_BIT];
    assign status_flag     = perm_ff[cfg_word_pkg::STATUS_FLAG_BIT];
    assign flag_filter     = flag_filter_ff;
    assign tid_word        = tid_ff;
    assign epc_default     = epc_ff;

    ////////////////////////////////////////////////////////////////////
    a_truncate_ignored: assert property (@(posedge mclk) disable iff (reset)
        (sel_stb && sel_truncate) |=> !sel_action && $stable(par_enc_ff) && $stable(pwr_chk_ff))
        else $error("truncated select had an effect");
    a_action_sticky: assert property (@(posedge mclk) disable iff (reset)
        par_enc_ff |=> par_enc_ff) else $error("action bit dropped");
    a_zero_write: assert property (@(posedge mclk) disable iff (reset)
        (perm_wr && wr_data[15] == 1'b0) |=> $stable(status_flag))
        else $error("zero write changed flag");
    a_one_toggles: assert property (@(posedge mclk) disable iff (reset)
        (perm_wr && wr_data[9]) |=> bs_max != $past(bs_max))
        else $error("one write did not toggle");
    a_permalock_hold: assert property (@(posedge mclk) disable iff (reset)
        (wr_stb && epc_lock == cfg_word_pkg::LOCK_PERMA) |=> $stable(perm_ff))
        else $error("permalocked word changed");
    a_blockwrite_hold: assert property (@(posedge mclk) disable iff (reset)
        (wr_stb && blk_wr) |=> $stable(perm_ff)) else $error("blockwrite toggled");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (reset)
        rd_valid |-> (rd_data & 16'h7deb) == 16'h0000) else $error("reserved bit set");
    a_power_match: assert property (@(posedge mclk) disable iff (reset)
        hit_pwr |=> sel_match == $past(power_ok)) else $error("power match wrong");
    a_handle_fixed: assert property (@(posedge mclk) disable iff (reset)
        (query_stb && par_enc_ff) |=> open_handle == 16'haaaa) else $error("bad handle");
    a_len_exact: assert property (@(posedge mclk) disable iff (reset)
        (sel_stb && sel_length != 8'h01) |=> !sel_action) else $error("bad length hit");
    c_par_enc: cover property (@(posedge mclk) disable iff (reset) hit_par ##[1:20] query_stb);
    c_pwr_ok: cover property (@(posedge mclk) disable iff (reset) hit_pwr && power_ok);
    c_flag_toggle: cover property (@(posedge mclk) disable iff (reset) perm_wr && wr_data[15]);
    c_flag_filter: cover property (@(posedge mclk) disable iff (reset)
        hit_flag ##[1:5000] (query_stb && filter_arm_ff));
    c_open_lock: cover property (@(posedge mclk) disable iff (reset)
        hit_pwr && (epc_lock == cfg_word_pkg::LOCK_PERMA));

    ////////////////////////////////////////////////////////////////////
    // Action bits: triggering, stickiness and select qualification
    a_pwr_sticky: assert property (@(posedge mclk) disable iff (reset)
        pwr_chk_ff |=> pwr_chk_ff) else $error("power check bit dropped");
    a_par_trigger: assert property (@(posedge mclk) disable iff (reset)
        hit_par |=> par_enc_ff && sel_action) else $error("parallel bit not set");
    a_pwr_trigger: assert property (@(posedge mclk) disable iff (reset)
        hit_pwr |=> pwr_chk_ff && sel_action) else $error("power bit not set");
    a_single_action: assert property (@(posedge mclk) disable iff (reset)
        !(hit_par && hit_pwr)) else $error("two actions from one select");
    a_mask_exact: assert property (@(posedge mclk) disable iff (reset)
        (sel_stb && !sel_mask) |=> !sel_action) else $error("zero mask triggered");
    a_ptr_exact: assert property (@(posedge mclk) disable iff (reset)
        (sel_stb && sel_pointer != cfg_word_pkg::PAR_ENC_ADDR
                 && sel_pointer != cfg_word_pkg::PWR_CHECK_ADDR) |=> !sel_action)
        else $error("inexact pointer triggered");
    a_any_lock: assert property (@(posedge mclk) disable iff (reset)
        (sel_live && sel_pointer == cfg_word_pkg::PWR_CHECK_ADDR && sel_length == 8'h01
         && sel_mask && epc_lock == cfg_word_pkg::LOCK_PERMA) |=> sel_action)
        else $error("lock blocked an action");
    a_state_kept: assert property (@(posedge mclk) disable iff (reset)
        ((hit_par || hit_pwr) && !perm_wr) |=> $stable(perm_ff))
        else $error("action select changed word");

    // Permanent bits: toggling, read view and write permission
    a_flag_toggle: assert property (@(posedge mclk) disable iff (reset)
        (perm_wr && wr_data[15]) |=> status_flag != $past(status_flag))
        else $error("flag did not toggle");
    a_read_view: assert property (@(posedge mclk) disable iff (reset)
        (rd_stb && rd_addr == cfg_word_pkg::CFG_WORD_ADDR) |=> rd_valid)
        else $error("read not answered");
    a_read_flag: assert property (@(posedge mclk) disable iff (reset)
        rd_valid |-> rd_data[15] == $past(perm_ff[15])) else $error("flag read wrong");
    a_locked_hold: assert property (@(posedge mclk) disable iff (reset)
        (wr_stb && epc_lock == cfg_word_pkg::LOCK_LOCKED && !secured) |=> $stable(perm_ff))
        else $error("locked word changed");
    a_done_lock: assert property (@(posedge mclk) disable iff (reset)
        wr_done |-> $past(epc_lock) != cfg_word_pkg::LOCK_PERMA)
        else $error("permalocked write accepted");
    a_cfg_addr: assert property (@(posedge mclk) disable iff (reset)
        wr_done |-> $past(wr_addr) == cfg_word_pkg::CFG_WORD_ADDR)
        else $error("write outside word");
    a_bs_default: assert property (@(posedge mclk) disable iff (reset)
        $fell(reset) |-> bs_max && !status_flag) else $error("bad default levels");

    // Inventory side effects and identity words
    a_open_sticky: assert property (@(posedge mclk) disable iff (reset)
        force_open |=> force_open && write_broadcast) else $error("open state dropped");
    a_filter_set: assert property (@(posedge mclk) disable iff (reset)
        (query_stb && hit_flag) |=> flag_filter) else $error("filter not set");
    a_filter_clear: assert property (@(posedge mclk) disable iff (reset)
        (query_stb && !filter_arm_ff && !hit_flag) |=> !flag_filter)
        else $error("filter not cleared");
    a_tid_indicator: assert property (@(posedge mclk) disable iff (reset)
        tid_word[95 - cfg_word_pkg::TID_CFG_IND_BIT]) else $error("indicator clear");
    a_epc_copy: assert property (@(posedge mclk) disable iff (reset)
        epc_default[47:0] == tid_word[47:0] && epc_default[63:48] == 16'h0000)
        else $error("epc not pre-serialized");
endmodule : cfg_word_ctrl

// ==== rtl/cfg_word_pkg.sv ====
// Constants for the configuration-word feature control of the tag.
// Assumes a decoded-command front end on the same clock as mclk.
package cfg_word_pkg;
    localparam logic [15:0] CFG_WORD_ADDR   = 16'h0200;
    localparam logic [15:0] PAR_ENC_ADDR    = 16'h0202;
    localparam logic [15:0] PWR_CHECK_ADDR  = 16'h0204;
    localparam logic [15:0] STATUS_FLAG_ADDR = 16'h020f;
    localparam int          PAR_ENC_BIT     = 2;
    localparam int          PWR_CHECK_BIT   = 4;
    localparam int          BS_STRENGTH_BIT = 9;
    localparam int          STATUS_FLAG_BIT = 15;
    localparam logic [15:0] PERM_MASK       = 16'h8200;
    localparam logic [15:0] PERM_RESET      = 16'h0200;
    localparam logic [7:0]  SEL_LEN_ONE     = 8'h01;
    localparam logic [15:0] PAR_ENC_HANDLE  = 16'haaaa;
    localparam int          TID_CFG_IND_BIT = 20;
    localparam logic [15:0] TID_EXTENDED_TID_HEADER_ZERO   = 16'h0000;
    localparam logic [15:0] TID_CLASS_ID    = 16'h0000;
    typedef enum logic [1:0] {
        LOCK_OPEN,
        LOCK_LOCKED,
        LOCK_PERMA
    } epc_lock_t;
endpackage : cfg_word_pkg

// ==== test/reader_model.sv ====
// Reader-side model: turns bench calls into decoded command strobes.
// Assumes the tag samples every strobe on the rising edge of mclk.
module reader_model #(
    parameter int CW_GAP = 4016  // RTCal of 16 cycles plus 80 us at 50 MHz
) (
    // Clock
    input  wire logic        mclk,
    // Memory access
    output logic             wr_stb,
    output logic             blk_wr,
    output logic [15:0]      wr_addr,
    output logic [15:0]      wr_data,
    output logic             rd_stb,
    output logic [15:0]      rd_addr,
    // Select and query
    output logic             sel_stb,
    output logic             sel_truncate,
    output logic [15:0]      sel_pointer,
    output logic [7:0]       sel_length,
    output logic             sel_mask,
    output logic             query_stb
);
    timeunit 1ns;
    timeprecision 1ps;
    int cw_left = 0;
    initial begin
        {wr_stb, blk_wr, rd_stb, sel_stb, sel_truncate, sel_mask, query_stb} = '0;
        {wr_addr, wr_data, rd_addr, sel_pointer, sel_length} = '0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Carrier stays on after a select before anything else is sent
    task automatic start();
        repeat (cw_left) @(posedge mclk);
        cw_left = 0;
        @(posedge mclk);
    endtask : start
    // Released fields are inverted so a stale value is never mistaken for data
    task automatic write_word(input logic [15:0] a, input logic [15:0] d, input logic b);
        start();
        wr_stb <= 1'b1;
        {blk_wr, wr_addr, wr_data} <= {b, a, d};
        @(posedge mclk);
        wr_stb <= 1'b0;
        {blk_wr, wr_addr, wr_data} <= ~{b, a, d};
    endtask : write_word
    task automatic read_word(input logic [15:0] a);
        start();
        rd_stb <= 1'b1;
        rd_addr <= a;
        @(posedge mclk);
        rd_stb <= 1'b0;
        rd_addr <= ~a;
    endtask : read_word
    task automatic select(input logic t, input logic [15:0] p, input logic [7:0] n,
                          input logic m);
        start();
        sel_stb <= 1'b1;
        {sel_truncate, sel_pointer, sel_length, sel_mask} <= {t, p, n, m};
        @(posedge mclk);
        sel_stb <= 1'b0;
        {sel_truncate, sel_pointer, sel_length, sel_mask} <= ~{t, p, n, m};
        cw_left = CW_GAP;
    endtask : select
    task automatic query();
        start();
        query_stb <= 1'b1;
        @(posedge mclk);
        query_stb <= 1'b0;
    endtask : query
endmodule : reader_model

// ==== test/tb_tag_config_word_feature_control.sv ====
// Bench for the configuration-word feature control.
// Assumes reader_model drives the command side; results sampled 1 ns after.
module tb_tag_config_word_feature_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [47:0] SN = 48'h0123_4567_89ab;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        secured = 1'b0;
    logic [1:0]  epc_lock = 2'h0;
    logic        power_ok = 1'b0;
    logic        wr_stb, blk_wr, rd_stb, sel_stb, sel_truncate, sel_mask, query_stb;
    logic [15:0] wr_addr, wr_data, rd_addr, sel_pointer, rd_data, open_handle;
    logic [7:0]  sel_length;
    logic        rd_valid, wr_done, sel_action, sel_match, force_open;
    logic        write_broadcast, bs_max, status_flag, flag_filter;
    logic [95:0] tid_word, epc_default;
    logic [4:0]  wtab [4] = '{5'b00010, 5'b01000, 5'b01101, 5'b10100};
    int          n_fail = 0;
    int          n_checks = 0;
    always #10 mclk = ~mclk;
    reader_model rdr (.mclk, .wr_stb, .blk_wr, .wr_addr, .wr_data, .rd_stb, .rd_addr,
        .sel_stb, .sel_truncate, .sel_pointer, .sel_length, .sel_mask, .query_stb);
    cfg_word_ctrl #(.SERIAL_DEFAULT(SN)) dut (.mclk, .reset, .wr_stb, .blk_wr, .wr_addr,
        .wr_data, .rd_stb, .rd_addr, .secured, .epc_lock, .sel_stb, .sel_truncate,
        .sel_pointer, .sel_length, .sel_mask, .query_stb, .power_ok, .rd_data, .rd_valid,
        .wr_done, .sel_action, .sel_match, .force_open, .open_handle, .write_broadcast,
        .bs_max, .status_flag, .flag_filter, .tid_word, .epc_default);
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [95:0] seen, input logic [95:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic wrap_up();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    task automatic rcheck(input logic [15:0] e);
        rdr.read_word(16'h0200);
        #1;
        check("rd_data", {rd_valid, rd_data}, {1'b1, e});
    endtask : rcheck
    task automatic wcheck(input logic [15:0] d, input logic b, input logic e);
        rdr.write_word(16'h0200, d, b);
        #1;
        check("wr_done", wr_done, e);
    endtask : wcheck
    task automatic scheck(input logic t, input logic [15:0] p, input logic [7:0] n,
                          input logic m, input logic e);
        rdr.select(t, p, n, m);
        #1;
        check("sel_action", sel_action, e);
    endtask : scheck
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        check("serial", {tid_word[47:0], epc_default[47:0]}, {SN, SN});
        check("ext_hdr", epc_default[63:48], 16'h0000);
        check("cfg_ind", tid_word[75], 1'b1);
        rcheck(16'h0200);
        check("levels", {bs_max, status_flag}, 2'b10);
        wcheck(16'h8000, 1'b0, 1'b1);
        rcheck(16'h8200);
        rdr.write_word(16'h0200, 16'h0000, 1'b0);
        rcheck(16'h8200);
        wcheck(16'hffff, 1'b0, 1'b1);
        rcheck(16'h0000);
        check("levels", {bs_max, status_flag}, 2'b00);
        wcheck(16'h0200, 1'b0, 1'b1);
        foreach (wtab[i]) begin
            @(posedge mclk);
            {epc_lock, secured} <= wtab[i][4:2];
            wcheck(16'h8000, wtab[i][1], wtab[i][0]);
        end
        rcheck(16'h8200);
        scheck(1'b1, 16'h0204, 8'h01, 1'b1, 1'b0);
        scheck(1'b0, 16'h0204, 8'h02, 1'b1, 1'b0);
        scheck(1'b0, 16'h0204, 8'h01, 1'b0, 1'b0);
        scheck(1'b0, 16'h0203, 8'h01, 1'b1, 1'b0);
        scheck(1'b0, 16'h0204, 8'h01, 1'b1, 1'b1);
        check("sel_match", sel_match, 1'b0);
        @(posedge mclk);
        power_ok <= 1'b1;
        scheck(1'b0, 16'h0204, 8'h01, 1'b1, 1'b1);
        check("sel_match", sel_match, 1'b1);
        rdr.query();
        #1;
        check("open", {force_open, flag_filter}, 2'b00);
        rcheck(16'h8210);
        scheck(1'b0, 16'h020f, 8'h01, 1'b1, 1'b0);
        check("sel_match", sel_match, 1'b1);
        rdr.query();
        #1;
        check("flag_filter", flag_filter, 1'b1);
        scheck(1'b0, 16'h0202, 8'h01, 1'b1, 1'b1);
        rdr.query();
        #1;
        check("open", {force_open, open_handle, write_broadcast}, {1'b1, 16'haaaa, 1'b1});
        @(posedge mclk);
        reset <= 1'b1;
        @(posedge mclk);
        reset <= 1'b0;
        #1;
        check("open", force_open, 1'b0);
        wrap_up();
    end
    // Selects dominate the run time through the carrier gap
    initial begin
        repeat (60000) @(posedge mclk);
        n_fail++;
        wrap_up();
    end
endmodule : tb_tag_config_word_feature_control
